/* bbsp_pkg.sv */
package bbsp_pkg;
  // APB byte offsets, one aligned word each
  localparam logic [7:0] OFF_CFG1 = 8'h00;
  localparam logic [7:0] OFF_CFG2 = 8'h04;
  localparam logic [7:0] OFF_RXS  = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_ERR  = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // Reset values
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] RXS_RST  = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  // First config field positions
  localparam int CFG1_BIDIR  = 0;
  localparam int CFG1_SYMIRQ = 1;
  localparam int CFG1_REDIR  = 2;
  // Second config page field
  localparam int CFG2_PAGE_LO = 6;
  // Receive setup field positions
  localparam int RXS_EN    = 0;
  localparam int RXS_QUART = 1;
  localparam int RXS_IDENT = 2;
  // Error flag positions
  localparam int ERR_OVF = 0;
  localparam int ERR_UNF = 1;
  localparam int ERR_FIR = 2;
  localparam int ERR_W   = 3;
  // Command register addresses (7 bit)
  localparam logic [6:0] CA_CFG1 = 7'h00;
  localparam logic [6:0] CA_CFG2 = 7'h01;
  localparam logic [6:0] CA_RXS  = 7'h02;
  localparam logic [6:0] CA_MASK = 7'h03;
  localparam logic [6:0] CA_ERR  = 7'h08;
  localparam logic [1:0] PAGE0   = 2'h0;
  // Transmit data word address bits 14:10
  localparam logic [4:0] TXD_ADDR = 5'h01;
  // Serial word timing in bit slots
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] HALF_MARK = 5'h09;
  localparam logic [3:0] RD_BITS   = 4'h8;
  // Serial clock divider limits: MCLK/2 and MCLK/4
  localparam logic [1:0] DIV_FAST = 2'h0;
  localparam logic [1:0] DIV_SLOW = 2'h1;
  // Transmit FIFO depth
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  // One-hot command register selector
  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_CFG1 = 6'b000010,
    SEL_CFG2 = 6'b000100,
    SEL_RXS  = 6'b001000,
    SEL_MASK = 6'b010000,
    SEL_ERR  = 6'b100000
  } bbsp_sel_t;
endpackage

/* bbsp_serial_host.sv */
// Design decisions made here: the address map and register access over APB.
module bbsp_serial_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sclk,
  input  wire logic        command_data_line_in,
  output logic             command_data_line_out,
  output logic             command_data_line_oe,
  input  wire logic        command_frame_sync,
  output logic             readback_data_line,
  output logic             readback_frame_sync,
  output logic             receive_data_line,
  output logic             receive_frame_sync,
  output logic             irq_n,
  input  wire logic        symbol_clk,
  input  wire logic        fir_overflow,
  input  wire logic        tx_word_demand,
  output logic      [15:0] tx_word,
  output logic             tx_word_valid,
  input  wire logic        rx_sample_valid,
  input  wire logic [15:0] rx_i,
  input  wire logic [15:0] rx_q
);
  import bbsp_pkg::*;

  // Map page and address to a command register
  function automatic bbsp_sel_t cmd_sel(input logic [1:0] page,
                                        input logic [6:0] addr);
    cmd_sel = SEL_NONE;
    if (addr == CA_CFG1) begin
      cmd_sel = SEL_CFG1;
    end else if (addr == CA_CFG2) begin
      cmd_sel = SEL_CFG2;
    end else if (page == PAGE0) begin
      case (addr)
        CA_RXS:  cmd_sel = SEL_RXS;
        CA_MASK: cmd_sel = SEL_MASK;
        CA_ERR:  cmd_sel = SEL_ERR;
        default: cmd_sel = SEL_NONE;
      endcase
    end
  endfunction

  logic [7:0]       cfg1_q;       // First config
  logic [7:0]       cfg2_q;       // Second config, page in 7:6
  logic [7:0]       rxs_q;        // Receive setup
  logic [ERR_W-1:0] mask_q;       // One enables a source
  logic [ERR_W-1:0] err_q;        // Sticky error flags
  logic [ERR_W-1:0] err_set;      // Flag events this cycle
  logic [ERR_W-1:0] err_clr;      // Flags reported by a read
  logic [1:0]       div_q;        // Serial clock divider
  logic [1:0]       div_lim;      // Divider limit for rate
  logic             rise_p;       // Serial clock rises now
  logic             fall_p;       // Serial clock falls now
  logic [4:0]       cmd_cnt_q;    // Command bits still due
  logic [15:0]      cmd_sh_q;     // Command shift register
  logic [15:0]      cmd_word;     // Completed command word
  logic [7:0]       cmd_hi;       // First byte once known
  logic             cmd_done;     // Command word complete
  logic             cmd_wr_p;     // Control write
  logic             half_p;       // First byte complete
  logic             rd_req;       // Read request decoded
  bbsp_sel_t        rd_sel;       // Read target
  bbsp_sel_t        wr_sel;       // Write target
  logic [7:0]       rd_val;       // Read data
  logic [15:0]      rb_word_q;    // Pending readback word
  logic             rb_pend_q;    // Readback word waiting
  logic [3:0]       od_cnt_q;     // Open-drain bits left
  logic [7:0]       od_sh_q;      // Open-drain shift data
  logic             od_oe_q;      // Pulling line low
  logic [15:0]      fifo_q [4];   // Transmit FIFO words
  logic [1:0]       wr_ptr_q;     // FIFO write index
  logic [1:0]       rd_ptr_q;     // FIFO read index
  logic [2:0]       count_q;      // FIFO occupancy
  logic             fifo_push;    // Transmit word arrives
  logic             fifo_full;    // No room left
  logic             fifo_empty;   // Nothing stored
  logic [15:0]      rx_i_q;       // Held I word
  logic [15:0]      rx_q_q;       // Held Q word
  logic             rx_i_pend_q;  // I word waiting
  logic             rx_q_pend_q;  // Q word waiting
  logic             keep_q;       // Decimation phase
  logic             src_pend [2]; // Port has a word
  logic [15:0]      src_word [2]; // Word for each port
  logic             take [2];     // Port loads a word
  logic             ser_dat [2];  // Port data bit
  logic             ser_fs [2];   // Port frame sync
  logic             apb_acc;      // APB access phase
  logic             apb_map;      // Address is mapped
  logic             redir;        // Readback on receive port
  logic             bidir;        // Command line two-way

  assign redir = cfg1_q[CFG1_REDIR];
  assign bidir = cfg1_q[CFG1_BIDIR];

  // Serial clock divider, MCLK/2 or MCLK/4
  assign div_lim = rxs_q[RXS_QUART] ? DIV_SLOW : DIV_FAST;
  assign rise_p  = (div_q >= div_lim) && !sclk;
  assign fall_p  = (div_q >= div_lim) && sclk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      sclk  <= 1'b0;
    end else if (div_q >= div_lim) begin
      div_q <= 2'h0;
      sclk  <= !sclk;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // Command decode, sampled on falling serial clock
  assign cmd_word = {cmd_sh_q[14:0], command_data_line_in};
  assign cmd_hi   = {cmd_sh_q[6:0], command_data_line_in};
  assign cmd_done = fall_p && (cmd_cnt_q == 5'h01);
  assign half_p   = fall_p && (cmd_cnt_q == HALF_MARK);
  assign fifo_push = cmd_done && cmd_word[15]
                     && (cmd_word[14:10] == TXD_ADDR);
  assign cmd_wr_p = cmd_done && cmd_word[15] && !fifo_push;
  assign rd_req   = half_p && !cmd_hi[7];
  assign rd_sel   = cmd_sel(cfg2_q[7:6], cmd_hi[6:0]);
  assign wr_sel   = cmd_sel(cfg2_q[7:6], cmd_word[14:8]);

  // Read value of the selected register
  always_comb begin
    case (rd_sel)
      SEL_CFG1: rd_val = cfg1_q;
      SEL_CFG2: rd_val = cfg2_q;
      SEL_RXS:  rd_val = rxs_q;
      SEL_MASK: rd_val = {5'h00, mask_q};
      SEL_ERR:  rd_val = {5'h00, err_q};
      default:  rd_val = 8'h00;
    endcase
  end

  // Command shift register and frame counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_cnt_q <= 5'h00;
      cmd_sh_q  <= 16'h0000;
    end else if (fall_p) begin
      // Shift while a frame is open
      if (cmd_cnt_q != 5'h00) begin
        cmd_sh_q  <= cmd_word;
        cmd_cnt_q <= cmd_cnt_q - 5'h01;
      end
      // Sync on last slot: next bit starts a frame
      if (command_frame_sync) begin
        cmd_cnt_q <= WORD_BITS;
      end
    end
  end

  // Readback word capture and hand-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_word_q <= 16'h0000;
      rb_pend_q <= 1'b0;
    end else begin
      if (rd_req) begin
        rb_word_q <= {1'b0, cmd_hi[6:0], rd_val};
      end
      if ((take[0] && !redir) || (take[1] && redir)) begin
        rb_pend_q <= 1'b0;
      end
      // Only non-bidirectional reads use a read port
      if (cmd_done && !cmd_word[15] && !bidir) begin
        rb_pend_q <= 1'b1;
      end
    end
  end

  // Open-drain answer in last eight bit slots
  assign command_data_line_out = 1'b0;
  assign command_data_line_oe  = od_oe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_cnt_q <= 4'h0;
      od_sh_q  <= 8'h00;
      od_oe_q  <= 1'b0;
    end else if (!bidir) begin
      od_cnt_q <= 4'h0;
      od_oe_q  <= 1'b0;
    end else if (half_p) begin
      if (rd_req) begin
        od_cnt_q <= RD_BITS;
        od_sh_q  <= rd_val;
      end
    end else if (rise_p) begin
      if (od_cnt_q != 4'h0) begin
        od_oe_q  <= !od_sh_q[7];
        od_sh_q  <= {od_sh_q[6:0], 1'b0};
        od_cnt_q <= od_cnt_q - 4'h1;
      end else begin
        od_oe_q  <= 1'b0;
      end
    end
  end

  // Transmit FIFO, four words
  assign fifo_full  = (count_q == FIFO_DEPTH);
  assign fifo_empty = (count_q == 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        fifo_q[k] <= 16'h0000;
      end
      wr_ptr_q      <= 2'h0;
      rd_ptr_q      <= 2'h0;
      count_q       <= 3'h0;
      tx_word       <= 16'h0000;
      tx_word_valid <= 1'b0;
    end else begin
      tx_word_valid <= tx_word_demand && !fifo_empty;
      if (fifo_push && !fifo_full) begin
        fifo_q[wr_ptr_q] <= cmd_word;
        wr_ptr_q         <= wr_ptr_q + 2'h1;
      end
      if (tx_word_demand && !fifo_empty) begin
        tx_word  <= fifo_q[rd_ptr_q];
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      count_q <= count_q + {2'h0, fifo_push && !fifo_full}
                 - {2'h0, tx_word_demand && !fifo_empty};
    end
  end

  // Flag events and read-clear requests
  always_comb begin
    err_set          = '0;
    err_set[ERR_OVF] = fifo_push && fifo_full;
    err_set[ERR_UNF] = tx_word_demand && fifo_empty;
    err_set[ERR_FIR] = fir_overflow;
    err_clr          = '0;
    // APB clears only the flags its setup cycle latched
    if (apb_acc && !pwrite && paddr == OFF_ERR) begin
      err_clr = prdata[ERR_W-1:0];
    end
    // Serial read reports and clears the live flags
    if (rd_req && rd_sel == SEL_ERR) begin
      err_clr = err_q;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // Interrupt pin or symbol clock reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n <= 1'b1;
    end else if (cfg1_q[CFG1_SYMIRQ]) begin
      irq_n <= symbol_clk;
    end else begin
      irq_n <= !(|(err_q & mask_q));
    end
  end

  // Configuration registers, APB wins a tie
  assign apb_acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_q <= CFG1_RST;
      cfg2_q <= CFG2_RST;
      rxs_q  <= RXS_RST;
      mask_q <= MASK_RST;
    end else if (apb_acc && pwrite) begin
      case (paddr)
        OFF_CFG1: cfg1_q <= pwdata[7:0];
        OFF_CFG2: cfg2_q <= pwdata[7:0];
        OFF_RXS:  rxs_q  <= pwdata[7:0];
        OFF_MASK: mask_q <= pwdata[ERR_W-1:0];
        default:  ;
      endcase
    end else if (cmd_wr_p) begin
      case (wr_sel)
        SEL_CFG1: cfg1_q <= cmd_word[7:0];
        SEL_CFG2: cfg2_q <= cmd_word[7:0];
        SEL_RXS:  rxs_q  <= cmd_word[7:0];
        SEL_MASK: mask_q <= cmd_word[ERR_W-1:0];
        default:  ;
      endcase
    end
  end

  // APB read data latched in the setup phase
  assign pready  = 1'b1;
  assign apb_map = (paddr <= OFF_STAT) && (paddr[1:0] == 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !apb_map;
      case (paddr)
        OFF_CFG1: prdata <= {24'h000000, cfg1_q};
        OFF_CFG2: prdata <= {24'h000000, cfg2_q};
        OFF_RXS:  prdata <= {24'h000000, rxs_q};
        OFF_MASK: prdata <= {29'h0, mask_q};
        OFF_ERR:  prdata <= {29'h0, err_q};
        OFF_STAT: prdata <= {26'h0, rb_pend_q, rx_i_pend_q,
                             rx_q_pend_q, count_q};
        default:  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Receive sample capture with optional decimation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_i_q      <= 16'h0000;
      rx_q_q      <= 16'h0000;
      rx_i_pend_q <= 1'b0;
      rx_q_pend_q <= 1'b0;
      keep_q      <= 1'b1;
    end else if (!rxs_q[RXS_EN]) begin
      rx_i_pend_q <= 1'b0;
      rx_q_pend_q <= 1'b0;
      keep_q      <= 1'b1;
    end else begin
      if (take[1] && !redir) begin
        if (rx_i_pend_q) begin
          rx_i_pend_q <= 1'b0;
        end else begin
          rx_q_pend_q <= 1'b0;
        end
      end
      if (rx_sample_valid) begin
        keep_q <= !keep_q || !rxs_q[RXS_QUART];
        if (keep_q || !rxs_q[RXS_QUART]) begin
          rx_i_q      <= rxs_q[RXS_IDENT] ? {rx_i[15:1], symbol_clk}
                                          : rx_i;
          rx_q_q      <= rx_q;
          rx_i_pend_q <= 1'b1;
          rx_q_pend_q <= 1'b1;
        end
      end
    end
  end

  // Word sources for readback and receive ports
  always_comb begin
    src_pend[0] = rb_pend_q && !redir;
    src_word[0] = rb_word_q;
    if (redir) begin
      src_pend[1] = rb_pend_q;
      src_word[1] = rb_word_q;
    end else begin
      src_pend[1] = rx_i_pend_q || rx_q_pend_q;
      src_word[1] = rx_i_pend_q ? rx_i_q : rx_q_q;
    end
  end

  // Output serialisers, driven on rising serial clock
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [4:0]  cnt_q; // Bits left
    logic [15:0] sh_q;  // Shift data
    logic        dat_q; // Line bit
    logic        fs_q;  // Frame sync
    assign take[p] = rise_p && src_pend[p] && (cnt_q <= 5'h01);
    assign ser_dat[p] = dat_q;
    assign ser_fs[p]  = fs_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 5'h00;
        sh_q  <= 16'h0000;
        dat_q <= 1'b0;
        fs_q  <= 1'b0;
      end else if (rise_p) begin
        if (cnt_q != 5'h00) begin
          dat_q <= sh_q[15];
          sh_q  <= {sh_q[14:0], 1'b0};
          cnt_q <= cnt_q - 5'h01;
        end else begin
          dat_q <= 1'b0;
        end
        fs_q <= take[p];
        if (take[p]) begin
          sh_q  <= src_word[p];
          cnt_q <= WORD_BITS;
        end
      end
    end
  end
  assign readback_data_line  = ser_dat[0];
  assign readback_frame_sync = ser_fs[0];
  assign receive_data_line   = ser_dat[1];
  assign receive_frame_sync  = ser_fs[1];

  // Checks on flags, interrupt, clock and ports
  irq_assert_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(err_q & mask_q)) && !cfg1_q[CFG1_SYMIRQ] |=> !irq_n)
    else $error("interrupt not asserted for unmasked flag");
  fifo_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_push && fifo_full |=> err_q[ERR_OVF]
    && (count_q == FIFO_DEPTH - {2'h0, $past(tx_word_demand)}))
    else $error("overflow flag missing");
  fifo_unf_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_word_demand && fifo_empty |=> err_q[ERR_UNF] && !tx_word_valid)
    else $error("underrun flag missing");
  fir_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    fir_overflow |=> err_q[ERR_FIR])
    else $error("filter overflow flag missing");
  mask_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (mask_q == MASK_RST) && irq_n)
    else $error("mask not cleared by reset");
  sclk_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sclk) && rxs_q[RXS_QUART] ##1 rxs_q[RXS_QUART] |-> sclk ##1 !sclk)
    else $error("quarter rate serial clock wrong");
  sclk_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sclk) && !rxs_q[RXS_QUART] |=> !sclk)
    else $error("half rate serial clock wrong");
  rb_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(readback_frame_sync) |-> $past(rb_pend_q) && !$past(redir))
    else $error("readback frame without a read");
  od_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    !bidir |=> !command_data_line_oe)
    else $error("command line driven while input only");
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_q[ERR_FIR] && err_clr == '0 |=> err_q[ERR_FIR])
    else $error("flag dropped without read");
  bidir_read_c: cover property (@(posedge pclk) disable iff (!presetn)
    rd_req && bidir ##[1:200] command_data_line_oe);
  fifo_full_c: cover property (@(posedge pclk) disable iff (!presetn)
    fifo_push && fifo_full);
  rx_frame_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(receive_frame_sync) && !redir);
endmodule

/* bbsp_host_model.sv */
// Host serial port: sends command frames, collects read and receive words
module bbsp_host_model (
  input  wire logic sclk,
  input  wire logic cmd_out,
  input  wire logic cmd_oe,
  output logic      cmd_in,
  output logic      cmd_fs,
  input  wire logic rb_d,
  input  wire logic rb_fs,
  input  wire logic rx_d,
  input  wire logic rx_fs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        drv = 1'b1;  // Host open-drain drive, 1 = released
  logic [15:0] cap;         // Line levels seen at each fall
  logic [15:0] rb_sh, rx_sh;
  logic [15:0] rb_q[$];     // Words from the read port
  logic [15:0] rx_q[$];     // Words from the receive port
  int          rb_n = 0;
  int          rx_n = 0;
  // Shared line with pull-up, either side may pull low
  assign cmd_in = (cmd_oe ? cmd_out : 1'b1) & drv;
  initial cmd_fs = 1'b0;
  // One frame: sync slot, then 16 bits MSB first on rising sclk
  task automatic send(input logic [15:0] w);
    @(posedge sclk);
    cmd_fs <= 1'b1;
    drv    <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sclk);
      cmd_fs <= 1'b0;
      drv    <= w[i];
      @(negedge sclk);
      cap = {cap[14:0], cmd_in};
    end
    drv <= 1'b1;
  endtask
  // Read port framing; a sync on the last bit restarts the count
  always @(negedge sclk) begin
    if (rb_n != 0) begin
      rb_sh = {rb_sh[14:0], rb_d};
      rb_n--;
      if (rb_n == 0) rb_q.push_back(rb_sh);
    end
    if (rb_fs) rb_n = 16;
  end
  // Receive port framing, I and Q arrive as separate words
  always @(negedge sclk) begin
    if (rx_n != 0) begin
      rx_sh = {rx_sh[14:0], rx_d};
      rx_n--;
      if (rx_n == 0) rx_q.push_back(rx_sh);
    end
    if (rx_fs) rx_n = 16;
  end
endmodule

/* bbsp_serial_host_bench.sv */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module bbsp_serial_host_bench import bbsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, sclk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cdi, cdo, coe, cfs, rbd, rbf, rxd, rxf, irq_n, slverr;
  logic        symbol_clk, fir_overflow, tx_word_demand, tx_word_valid;
  logic        rx_sample_valid, v;
  logic [15:0] tx_word, rx_i, rx_q, w;
  int          errors = 0;
  int          check_count = 0;
  time         p;
  always #5 pclk = ~pclk;
  bbsp_serial_host dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .command_data_line_in(cdi), .command_data_line_out(cdo),
    .command_data_line_oe(coe), .command_frame_sync(cfs),
    .readback_data_line(rbd), .readback_frame_sync(rbf),
    .receive_data_line(rxd), .receive_frame_sync(rxf), .irq_n(irq_n),
    .symbol_clk(symbol_clk), .fir_overflow(fir_overflow),
    .tx_word_demand(tx_word_demand), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .rx_sample_valid(rx_sample_valid),
    .rx_i(rx_i), .rx_q(rx_q));
  bbsp_host_model host (.sclk(sclk), .cmd_out(cdo), .cmd_oe(coe),
    .cmd_in(cdi), .cmd_fs(cfs), .rb_d(rbd), .rb_fs(rbf), .rx_d(rxd),
    .rx_fs(rxf));
  // APB transfer: setup, then access until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    slverr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bounded wait for a number of collected words
  task wait_q(input bit rx, input int n);
    repeat (3000) begin
      if ((rx ? host.rx_q.size() : host.rb_q.size()) >= n) break;
      @(posedge pclk);
    end
  endtask
  task pulse_fir;
    @(posedge pclk);
    fir_overflow <= ~fir_overflow;
    @(posedge pclk);
    fir_overflow <= ~fir_overflow;
    wt(3);
  endtask
  // One demand from the transmit path, returns what was popped
  task take;
    @(posedge pclk);
    tx_word_demand <= 1'b1;
    @(posedge pclk);
    tx_word_demand <= 1'b0;
    v = 1'b0;
    repeat (3) begin
      #1;
      if (tx_word_valid === 1'b1 && !v) begin
        v = 1'b1;
        w = tx_word;
      end
      @(posedge pclk);
    end
  endtask
  task sample(input logic [15:0] i, input logic [15:0] q);
    @(posedge pclk);
    rx_sample_valid <= 1'b1;
    rx_i <= i;
    rx_q <= q;
    @(posedge pclk);
    rx_sample_valid <= 1'b0;
  endtask
  // Period of sclk, second of two to skip a divider change
  task per;
    time t0;
    repeat (2) begin
      @(posedge sclk);
      t0 = $time;
      @(posedge sclk);
      p = $time - t0;
    end
  endtask
  // Reset state, unmapped access, masked flag
  task t_reset;
    apb(0, OFF_MASK, 0);
    `CHK(rd, 32'h0)
    apb(0, 8'h18, 0);
    `CHK(slverr, 1'b1)
    pulse_fir;
    `CHK(irq_n, 1'b1)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h4)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h0)
  endtask
  // Serial writes, reads, paging
  task t_cmd;
    host.send(16'h8305);
    apb(0, OFF_MASK, 0);
    `CHK(rd, 32'h5)
    wt(100);
    `CHK(host.rb_q.size(), 0)
    host.send(16'h0300);
    wait_q(0, 1);
    `CHK(host.rb_q.pop_front(), 16'h0305)
    host.send(16'h8140);
    host.send(16'h8307);
    apb(0, OFF_MASK, 0);
    `CHK(rd, 32'h5)
    host.send(16'h0100);
    wait_q(0, 1);
    `CHK(host.rb_q.pop_front(), 16'h0140)
    host.send(16'h8100);
  endtask
  // Read answer on the shared command line
  task t_bidir;
    apb(1, OFF_CFG1, 1);
    host.send(16'h03ff);
    `CHK(host.cap[7:0], 8'h05)
    wt(100);
    `CHK(coe, 1'b0)
    `CHK(host.rb_q.size(), 0)
    apb(1, OFF_CFG1, 4);
    host.send(16'h0300);
    wait_q(1, 1);
    `CHK(host.rx_q.pop_front(), 16'h0305)
    `CHK(host.rb_q.size(), 0)
    apb(1, OFF_CFG1, 0);
  endtask
  // Transmit FIFO overflow and underrun
  task t_fifo;
    apb(1, OFF_MASK, 7);
    for (int i = 0; i < 5; i++) host.send(16'h86a0 + 16'(i));
    wt(3);
    `CHK(irq_n, 1'b0)
    apb(0, OFF_STAT, 0);
    `CHK(rd, 32'h4)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h1)
    wt(3);
    `CHK(irq_n, 1'b1)
    for (int i = 0; i < 4; i++) begin
      take;
      `CHK(w, 16'h86a0 + 16'(i))
    end
    take;
    `CHK(v, 1'b0)
    wt(3);
    `CHK(irq_n, 1'b0)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h2)
  endtask
  // Filter overflow, then masked off
  task t_fir;
    pulse_fir;
    `CHK(irq_n, 1'b0)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h4)
    apb(1, OFF_MASK, 3);
    pulse_fir;
    `CHK(irq_n, 1'b1)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h4)
    pulse_fir;
    host.send(16'h0800);
    wait_q(0, 1);
    `CHK(host.rb_q.pop_front(), 16'h0804)
    apb(0, OFF_ERR, 0);
    `CHK(rd, 32'h0)
  endtask
  // Symbol clock on the interrupt pin
  task t_symirq;
    apb(1, OFF_CFG1, 2);
    symbol_clk <= ~symbol_clk;
    wt(3);
    `CHK(irq_n, 1'b1)
    symbol_clk <= ~symbol_clk;
    wt(3);
    `CHK(irq_n, 1'b0)
    apb(1, OFF_CFG1, 0);
  endtask
  // Receive stream: idle, full rate, ident, quarter rate
  task t_rx;
    sample(16'h1234, 16'h5678);
    wt(100);
    `CHK(host.rx_q.size(), 0)
    apb(1, OFF_RXS, 1);
    per;
    `CHK(p, 64'd20)
    sample(16'hbeef, 16'h0123);
    wait_q(1, 2);
    `CHK(host.rx_q.pop_front(), 16'hbeef)
    `CHK(host.rx_q.pop_front(), 16'h0123)
    apb(1, OFF_RXS, 5);
    sample(16'habcd, 16'h4321);
    wait_q(1, 2);
    `CHK(host.rx_q.pop_front(), 16'habcc)
    `CHK(host.rx_q.pop_front(), 16'h4321)
    apb(1, OFF_RXS, 3);
    per;
    `CHK(p, 64'd40)
    sample(16'h1111, 16'h2222);
    wt(150);
    sample(16'h3333, 16'h4444);
    wt(400);
    `CHK(host.rx_q.size(), 2)
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence, reset held for 16 cycles
  initial begin
    {presetn, psel, penable, pwrite, symbol_clk, fir_overflow} = '0;
    {tx_word_demand, rx_sample_valid, paddr, pwdata, rx_i, rx_q} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_cmd;
    t_bidir;
    t_fifo;
    t_fir;
    t_symirq;
    t_rx;
    tally_and_finish;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    errors++;
    tally_and_finish;
  end
endmodule
